// File: src/gcr_cfg.svh
/*
 * Offsets, field positions, reset values and gain step figures for the
 * coarse receive / fine transmit gain register pair.
 * Assumes an 8-bit register address space on the control port.
 */
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH

`define GCR_ADDR_W          8
`define GCR_DATA_W          8
`define GCR_OFF_RX_COARSE   8'h27
`define GCR_OFF_TX_FINE     8'h28
`define GCR_MAG_MSB         3
`define GCR_MAG_LSB         0
`define GCR_DIR_BIT         4
`define GCR_RSVD_ZERO       3'h0
`define GCR_RST_MAG         4'h0
`define GCR_RST_DIR         1'b0
`define GCR_RX_SAT_CODE     4'hC
`define GCR_RX_STEP_CDB     8'h0A
`define GCR_TX_STEP_CDB     8'h01
`define GCR_ZERO_DATA       8'h00

`endif

// File: src/gcr_pkg.sv
/*
 * Types shared by the gain register bank.
 * Assumes gcr_cfg.svh gives widths.
 */
package gcr_pkg;
    // Sense of a gain stage
    typedef enum logic {GCR_GAIN, GCR_ATTEN} gcr_dir_t;
    // One stage setting
    typedef struct packed {
        logic       dir;
        logic [3:0] mag;
    } gcr_stage_t;
endpackage

// File: src/gcr_stage_if.sv
/*
 * Carries one stage setting from the register bank to its decoder.
 * Assumes a single clock domain.
 */
interface gcr_stage_if;
    logic       dir;
    logic [3:0] mag;
    logic       atten;
    logic [7:0] level_cdb;
    modport bank (output dir, output mag, input atten, input level_cdb);
    modport dec  (input dir, input mag, output atten, output level_cdb);
endinterface

// File: src/gcr_stage_dec.sv
/*
 * Turns a direction bit and magnitude code into an attenuation flag and an unsigned level in
 * tenths of a dB. Assumes settings come from flip-flops on clk.
 */
`include "gcr_cfg.svh"

module gcr_stage_dec #(
    parameter bit         SAT_12 = 1'b0,
    parameter logic [7:0] STEP   = 8'h01
) (
    // Setting in, level out
    gcr_stage_if.dec st
);
    logic [3:0] eff_mag;

    // Gain sense saturates upper codes on the coarse stage only
    always_comb
    begin
        eff_mag = st.mag;
        if (SAT_12 && !st.dir && (st.mag[3:2] == 2'b11))
            eff_mag = `GCR_RX_SAT_CODE;                      // [R4]
    end

    // Zero code applies zero level, either sense
    assign st.atten     = st.dir && (st.mag != `GCR_RST_MAG); // [R1] [R3] [R6] [R8]
    assign st.level_cdb = 8'({4'h0, eff_mag} * STEP);         // [R2] [R5] [R7] [R9]
endmodule

// File: src/gcr_regs.sv
/*
 * Coarse receive gain and fine transmit gain control registers with
 * their decoded levels for the analog path.
 * Assumes a one-cycle strobe control port on clk, synchronous reset.
 */
// The address-and-strobe port was left to the implementer.
`include "gcr_cfg.svh"

// Contract
// [R1] Receive direction bit picks gain or attenuation
// [R2] Receive step one dB, +12/-15 limits
// [R3] Receive code zero gives zero dB
// [R4] Receive gain codes 11xx saturate twelve dB
// [R5] Receive attenuation linear, 1111 is fifteen
// [R6] Transmit direction bit picks gain or attenuation
// [R7] Transmit step tenth dB, 1.5 limit
// [R8] Transmit code zero gives zero dB
// [R9] Transmit code 1111 gives 1.5 dB
// [R10] Upper three bits read zero, writes dropped
module gcr_regs (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Receive coarse stage level, tenths of dB
    output logic            rx_atten,
    output logic      [7:0] rx_level_cdb,
    // Transmit fine stage level, tenths of dB
    output logic            tx_atten,
    output logic      [7:0] tx_level_cdb
);
    gcr_pkg::gcr_stage_t rx_stage;
    gcr_pkg::gcr_stage_t tx_stage;
    gcr_stage_if         rx_if ();
    gcr_stage_if         tx_if ();

    // Receive coarse register, only the low five bits kept
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_stage.dir <= `GCR_RST_DIR;
            rx_stage.mag <= `GCR_RST_MAG;
        end
        else if (wr && addr == `GCR_OFF_RX_COARSE)
        begin
            rx_stage.dir <= wdata[`GCR_DIR_BIT];                    // [R1] [R10]
            rx_stage.mag <= wdata[`GCR_MAG_MSB:`GCR_MAG_LSB];
        end
    end

    // Transmit fine register, only the low five bits kept
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_stage.dir <= `GCR_RST_DIR;
            tx_stage.mag <= `GCR_RST_MAG;
        end
        else if (wr && addr == `GCR_OFF_TX_FINE)
        begin
            tx_stage.dir <= wdata[`GCR_DIR_BIT];                    // [R6] [R10]
            tx_stage.mag <= wdata[`GCR_MAG_MSB:`GCR_MAG_LSB];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk)
    begin
        if (srst || !rd)
            rdata <= `GCR_ZERO_DATA;
        else if (addr == `GCR_OFF_RX_COARSE)
            rdata <= {`GCR_RSVD_ZERO, rx_stage.dir, rx_stage.mag};  // [R10]
        else if (addr == `GCR_OFF_TX_FINE)
            rdata <= {`GCR_RSVD_ZERO, tx_stage.dir, tx_stage.mag};  // [R10]
        else
            rdata <= `GCR_ZERO_DATA;
    end

    // Stage settings to the decoders
    assign rx_if.dir = rx_stage.dir;
    assign rx_if.mag = rx_stage.mag;
    assign tx_if.dir = tx_stage.dir;
    assign tx_if.mag = tx_stage.mag;

    gcr_stage_dec #(
        .SAT_12 (1'b1),
        .STEP   (`GCR_RX_STEP_CDB)
    ) u_rx_dec (
        .st (rx_if.dec)
    );

    gcr_stage_dec #(
        .SAT_12 (1'b0),
        .STEP   (`GCR_TX_STEP_CDB)
    ) u_tx_dec (
        .st (tx_if.dec)
    );

    // Decoded levels registered for the analog path
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_atten     <= 1'b0;
            rx_level_cdb <= `GCR_ZERO_DATA;
            tx_atten     <= 1'b0;
            tx_level_cdb <= `GCR_ZERO_DATA;
        end
        else
        begin
            rx_atten     <= rx_if.atten;                            // [R1] [R3]
            rx_level_cdb <= rx_if.level_cdb;                        // [R2] [R4] [R5]
            tx_atten     <= tx_if.atten;                            // [R6] [R8]
            tx_level_cdb <= tx_if.level_cdb;                        // [R7] [R9]
        end
    end
endmodule

// File: verif/gcr_chk.sv
/* Port assertions for gcr_regs.
   Assumes levels settle two edges after a write. */
module gcr_chk (
    // All ports of gcr_regs
    input wire logic       clk, srst, wr, rd, rx_atten, tx_atten,
    input wire logic [7:0] addr, wdata, rdata, rx_level_cdb, tx_level_cdb
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Writes to each register
    wire wx = wr && addr == 8'h27;
    wire wt = wr && addr == 8'h28;
    rx_zero_a: assert property (wx && !wdata[3:0] |-> ##2 !rx_level_cdb && !rx_atten)
        else $error("rx zero");
    rx_sat_a: assert property (wx && !wdata[4] && &wdata[3:2] |-> ##2 rx_level_cdb == 8'h78)
        else $error("rx sat");
    rx_step_a: assert property (wx && !wdata[4] && wdata[3:0] < 4'hC |-> ##2
        rx_level_cdb == $past(wdata[3:0], 2) * 8'h0A) else $error("rx step");
    rx_gain_a: assert property (wx && !wdata[4] |-> ##2 !rx_atten)
        else $error("rx dir");
    rx_att_a: assert property (wx && wdata[4] |-> ##2 rx_atten == |$past(wdata[3:0], 2)
        && rx_level_cdb == $past(wdata[3:0], 2) * 8'h0A) else $error("rx att");
    tx_lvl_a: assert property (wt |-> ##2 tx_level_cdb == $past(wdata[3:0], 2))
        else $error("tx lvl");
    tx_dir_a: assert property (wt |-> ##2 tx_atten == ($past(wdata[4], 2) && |$past(wdata[3:0], 2)))
        else $error("tx dir");
    rsvd_zero_a: assert property (rd |=> rdata[7:5] == 3'h0)
        else $error("rsvd");
    cover property (wx && !wdata[4] && &wdata[3:2]);
    cover property (wt && wdata[4]);
    cover property (rd && addr == 8'h28);
endmodule

bind gcr_regs gcr_chk chk (.*);

// File: verif/tb.sv
/* Self-checking bench for gcr_regs.
   Assumes one clock and the strobe register port. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, srst = 1, wr = 0, rd = 0, rx_atten, tx_atten, rp = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx_level_cdb, tx_level_cdb;
    logic [7:0] mdl [2] = '{8'h00, 8'h00};
    logic [7:0] rq [$];
    logic [9:0] lq [$];
    logic [1:0] wp = 2'h0;
    logic [31:0] seed = 46221;
    int         mismatches = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    gcr_regs uut (.*);
    // Compare one read data byte
    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (e !== g)
        begin
            mismatches++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Compare one decoded stage level
    task automatic cmp(input logic [9:0] e, input logic [9:0] g);
        n_checks++;
        if (e !== g)
        begin
            mismatches++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One bus cycle, noting what it should produce
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        m = d[3:0];
        if (!a[3])
            m = (!d[4] && &d[3:2] ? 8'h0C : m) * 8'h0A;
        if (w && (a == 8'h27 || a == 8'h28))
        begin
            lq.push_back({a[3], d[4] && |d[3:0], m});
            mdl[a[3]] = {3'h0, d[4:0]};
        end
        if (!w)
            rq.push_back(a == 8'h27 || a == 8'h28 ? mdl[a[3]] : 8'h00);
    endtask
    // Track strobes and cut a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rp <= rd;
        wp <= {wp[0], wr && (addr == 8'h27 || addr == 8'h28)};
        if (cyc == 1000)
        begin
            mismatches++;
            print_verdict;
        end
    end
    // Take the oldest note when a result appears
    always @(negedge clk)
    begin
        if (rp)
            cmp_rd(rq.pop_front(), rdata);
        if (wp[1] && lq[0][9])
            cmp(lq.pop_front(), {1'b1, tx_atten, tx_level_cdb});
        else if (wp[1])
            cmp(lq.pop_front(), {1'b0, rx_atten, rx_level_cdb});
    end
    // Reset values, every code both ways, then random traffic
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        acc(1'b0, 8'h27, 8'h00);
        acc(1'b0, 8'h28, 8'h00);
        for (int i = 0; i < 32; i++)
        begin
            acc(1'b1, 8'h27, {3'h7, i[4:0]});
            acc(1'b1, 8'h28, {3'h5, i[4:0]});
            acc(1'b0, 8'h27, 8'h00);
            acc(1'b0, 8'h28, 8'h00);
        end
        repeat (60)
        begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            acc(seed[8], 8'h26 + seed[1:0], seed[23:16]);
        end
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (4) @(posedge clk);
        print_verdict;
    end
endmodule
